/* design/dtc_core.v */
// dynamic termination control: picks nominal or write termination strength
// assumes command clock, pin and write command come from outside mclk domain
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`include "dtc_defines.vh"

module dtc_core #(
  parameter HIST_DEPTH = 40,
  parameter CK_PERIOD_NS = `DTC_CK_PERIOD_NS
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire cmd_clk_i,
  input wire termination_pin_i,
  input wire cmd_write_i,
  input wire cmd_chop_i,
  output reg term_on_o,
  output reg write_sel_o,
  output reg [7:0] term_ohms_o,
  output reg term_undefined_o,
  output reg code_reserved_o
);

  // undefined window after a change, longest time rounded down, at least one
  localparam integer SKEW_RAW =
    (CK_PERIOD_NS * `DTC_SKEW_MAX_TENTHS / 10) / `DTC_MCLK_PERIOD_NS;
  // the settle counter is four bits wide, so the window saturates at 15 mclk
  localparam integer SKEW_INT = (SKEW_RAW < 1) ? 1 : ((SKEW_RAW > 15) ? 15 : SKEW_RAW);
  localparam [3:0] SKEW_CYC = SKEW_INT[3:0];

  // latency offset and window lengths at the width of the latency sum
  localparam [4:0] WL_OFS = `DTC_WL_OFFSET;
  localparam [4:0] CHOP_LEN = `DTC_CHOP_HOLD;
  localparam [4:0] FULL_LEN = `DTC_FULL_HOLD;

  // ----------------------------------------
  // operating notes
  // ----------------------------------------
  // every link input crosses two flip-flops, so a command clock edge is seen
  // about two mclk late; pin, write and chop share that delay and stay aligned.
  // the controller must hold pin, write and chop steady around each rising
  // command clock edge, since they are sampled through the same delay.
  // the history must be deeper than the largest latency plus the full window,
  // otherwise late taps read zero and the write window is cut short.
  // the latency fields are used live; changing them while the link is busy
  // shifts every pending window, so software changes them only when idle.
  // a write that meets a pin-derived off state leaves termination off at zero ohm.
  // the write field at zero disables switching, so writes see nominal strength.
  // every change of state, off included, opens the settling window, during
  // which the applied strength must be treated as unknown by the far side.
  // reserved codes give zero ohm and raise the reserved flag; nothing else
  // about them is guarded here.
  // a latency sum below two clamps to zero rather than wrapping round.

  // ----------------------------------------
  // decode functions
  // ----------------------------------------

  // nominal field to ohm, zero for off or reserved
  function [7:0] nom_ohms;
    input [2:0] code;
    begin
      case (code)
        3'h1: nom_ohms = `DTC_OHM_60;
        3'h2: nom_ohms = `DTC_OHM_120;
        3'h3: nom_ohms = `DTC_OHM_40;
        3'h4: nom_ohms = `DTC_OHM_20;
        3'h5: nom_ohms = `DTC_OHM_30;
        default: nom_ohms = 8'h00;
      endcase
    end
  endfunction

  // write field to ohm, zero for no switching or reserved
  function [7:0] wr_ohms;
    input [1:0] code;
    begin
      case (code)
        2'h1: wr_ohms = `DTC_OHM_60;
        2'h2: wr_ohms = `DTC_OHM_120;
        default: wr_ohms = 8'h00;
      endcase
    end
  endfunction

  // register decode, one-hot: mode one, mode two, latency, status
  function [3:0] reg_hit;
    input [3:0] a;
    begin
      if (a == `DTC_OFS_MODE_REG_ONE) begin
        reg_hit = 4'h1;
      end else if (a == `DTC_OFS_MODE_REG_TWO) begin
        reg_hit = 4'h2;
      end else if (a == `DTC_OFS_LATENCY) begin
        reg_hit = 4'h4;
      end else if (a == `DTC_OFS_STATUS) begin
        reg_hit = 4'h8;
      end else begin
        reg_hit = 4'h0;
      end
    end
  endfunction

  // reserved nominal codes, 110 and 111
  function nom_bad;
    input [2:0] code;
    begin
      nom_bad = code[2] & code[1];
    end
  endfunction

  // reserved write code, 11
  function wr_bad;
    input [1:0] code;
    begin
      wr_bad = &code;
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // register map, fields in the low bits, upper bits read zero:
  //   mode one  nominal strength code, three bits
  //   mode two  write strength code, two bits
  //   latency   column write latency in [3:0], additive latency in [7:4]
  //   status    ohms [7:0], on [8], write strength [9], settling [10], reserved [11]
  reg [2:0] nom_code_r;
  reg [1:0] wr_code_r;
  reg [3:0] cwl_r;
  reg [3:0] al_r;

  // software writes to the mode fields and latencies
  always @(posedge mclk_i) begin
    if (rst_i) begin
      nom_code_r <= `DTC_RST_NOM;
      wr_code_r <= `DTC_RST_WR;
      cwl_r <= `DTC_RST_CWL;
      al_r <= `DTC_RST_AL;
    end else if (wr_i) begin
      if (reg_hit(addr_i) == 4'h1) begin
        nom_code_r <= wdata_i[`DTC_NOM_LSB +: 3];
      end else if (reg_hit(addr_i) == 4'h2) begin
        wr_code_r <= wdata_i[`DTC_WR_LSB +: 2];
      end else if (reg_hit(addr_i) == 4'h4) begin
        cwl_r <= wdata_i[`DTC_CWL_LSB +: 4];
        al_r <= wdata_i[`DTC_AL_LSB +: 4];
      end
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      if (reg_hit(addr_i) == 4'h1) begin
        rdata_o <= {29'h0, nom_code_r};
      end else if (reg_hit(addr_i) == 4'h2) begin
        rdata_o <= {30'h0, wr_code_r};
      end else if (reg_hit(addr_i) == 4'h4) begin
        rdata_o <= {24'h0, al_r, cwl_r};
      end else if (reg_hit(addr_i) == 4'h8) begin
        rdata_o <= {20'h0, code_reserved_o, term_undefined_o, write_sel_o,
                    term_on_o, term_ohms_o};
      end else begin
        rdata_o <= 32'h0;
      end
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // link sampling
  // ----------------------------------------
  reg ck_prev_r;
  wire [3:0] link_raw;
  wire [3:0] link_s;

  // bit order of the sampled link vector
  assign link_raw = {cmd_chop_i, cmd_write_i, termination_pin_i, cmd_clk_i};

  // two flip-flops per link input; logic reads only the second
  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= link_raw[s];
          sync_r <= meta_r;
        end
      end
      assign link_s[s] = sync_r;
    end
  endgenerate

  // previous synchronised command clock for edge finding
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= link_s[0];
    end
  end

  // one-cycle enable on each rising command clock edge
  wire tick = link_s[0] & ~ck_prev_r;
  wire pin_s = link_s[1];
  wire wr_s = link_s[2];
  wire chop_s = link_s[3];

  // ----------------------------------------
  // latency and history
  // ----------------------------------------
  wire [4:0] wl = {1'b0, cwl_r} + {1'b0, al_r};
  // turn-on, turn-off and switch latencies are all write latency minus two
  wire [4:0] lat_nxt = (wl < WL_OFS) ? 5'h0 : wl - WL_OFS;
  wire dyn_en = |wr_code_r;
  reg [4:0] lat_r;

  // latency held in a flip-flop so the tap compares start from a register
  always @(posedge mclk_i) begin
    if (rst_i) begin
      lat_r <= 5'h0;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  reg [HIST_DEPTH-1:0] pin_hist_r;
  reg [HIST_DEPTH-1:0] chop_hist_r;
  reg [HIST_DEPTH-1:0] full_hist_r;
  wire [HIST_DEPTH-1:0] pin_new = {pin_hist_r[HIST_DEPTH-2:0], pin_s};
  // every write variant counts, auto-precharge or not, chop picks the length
  wire [HIST_DEPTH-1:0] chop_new = {chop_hist_r[HIST_DEPTH-2:0], wr_s & chop_s};
  wire [HIST_DEPTH-1:0] full_new = {full_hist_r[HIST_DEPTH-2:0], wr_s & ~chop_s};

  // shift pin and write history once per command clock
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_hist_r <= {HIST_DEPTH{1'b0}};
      chop_hist_r <= {HIST_DEPTH{1'b0}};
      full_hist_r <= {HIST_DEPTH{1'b0}};
    end else if (tick) begin
      pin_hist_r <= pin_new;
      chop_hist_r <= chop_new;
      full_hist_r <= full_new;
    end
  end

  // ----------------------------------------
  // termination decision
  // ----------------------------------------
  reg on_nxt;
  reg wsel_nxt;
  reg [7:0] ohms_nxt;
  wire [HIST_DEPTH-1:0] chop_win;
  wire [HIST_DEPTH-1:0] full_win;

  // one window test per history tap; tap g holds the write sampled g ticks ago
  genvar g;
  generate
    for (g = 0; g < HIST_DEPTH; g = g + 1) begin : g_tap
      localparam [6:0] TAP = g;
      wire [6:0] lo = {2'h0, lat_r};
      assign chop_win[g] = chop_new[g] & (TAP >= lo) &
                           (TAP < lo + {2'h0, CHOP_LEN});
      assign full_win[g] = full_new[g] & (TAP >= lo) &
                           (TAP < lo + {2'h0, FULL_LEN});
    end
  endgenerate

  // pin delayed by the latency sets on/off; an open write window selects strength
  always @* begin
    on_nxt = pin_new[lat_r];
    wsel_nxt = (|chop_win) | (|full_win);
    wsel_nxt = wsel_nxt & dyn_en;
    // nominal strength when on and no write window is open, zero ohm when off
    if (!on_nxt) begin
      ohms_nxt = 8'h00;
    end else if (wsel_nxt) begin
      ohms_nxt = wr_ohms(wr_code_r);
    end else begin
      ohms_nxt = nom_ohms(nom_code_r);
    end
  end

  // ----------------------------------------
  // outputs and change window
  // ----------------------------------------
  reg [3:0] skew_cnt_r;
  wire change = tick & ((on_nxt != term_on_o) | (ohms_nxt != term_ohms_o) |
                        ((wsel_nxt & on_nxt) != write_sel_o));

  // update the termination state on each command clock edge
  always @(posedge mclk_i) begin
    if (rst_i) begin
      term_on_o <= 1'b0;
      write_sel_o <= 1'b0;
      term_ohms_o <= 8'h00;
    end else if (tick) begin
      term_on_o <= on_nxt;
      write_sel_o <= wsel_nxt & on_nxt;
      term_ohms_o <= ohms_nxt;
    end
  end

  // value is undefined for the settling time after any change
  always @(posedge mclk_i) begin
    if (rst_i) begin
      skew_cnt_r <= 4'h0;
      term_undefined_o <= 1'b0;
    end else if (change) begin
      skew_cnt_r <= SKEW_CYC;
      term_undefined_o <= 1'b1;
    end else begin
      if (skew_cnt_r != 4'h0) begin
        skew_cnt_r <= skew_cnt_r - 4'h1;
      end
      term_undefined_o <= (skew_cnt_r > 4'h1);
    end
  end

  // flags a reserved code in either field
  always @(posedge mclk_i) begin
    if (rst_i) begin
      code_reserved_o <= 1'b0;
    end else begin
      code_reserved_o <= nom_bad(nom_code_r) | wr_bad(wr_code_r);
    end
  end

endmodule

/* design/dtc_defines.vh */
// constants for the dynamic termination control block
// assumes mclk at 25 MHz and a sampled command clock of 320 ns
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTC_OFS_MODE_REG_ONE 4'h0
`define DTC_OFS_MODE_REG_TWO 4'h4
`define DTC_OFS_LATENCY 4'h8
`define DTC_OFS_STATUS 4'hc

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DTC_NOM_LSB 0
`define DTC_WR_LSB 0
`define DTC_CWL_LSB 0
`define DTC_AL_LSB 4
`define DTC_RST_NOM 3'h0
`define DTC_RST_WR 2'h0
`define DTC_RST_CWL 4'h5
`define DTC_RST_AL 4'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define DTC_WL_OFFSET 2
`define DTC_CHOP_HOLD 4
`define DTC_FULL_HOLD 6
`define DTC_CK_PERIOD_NS 320
`define DTC_MCLK_PERIOD_NS 40
`define DTC_SKEW_MAX_TENTHS 7

// ----------------------------------------
// termination values in ohm
// ----------------------------------------
`define DTC_OHM_20 8'h14
`define DTC_OHM_30 8'h1e
`define DTC_OHM_40 8'h28
`define DTC_OHM_60 8'h3c
`define DTC_OHM_120 8'h78

`endif

/* testbench/dtc_core_assertions.sv */
// checker for the dtc_core ports
// assumes bind onto every dtc_core
`timescale 1ns/10ps
module dtc_core_assertions (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire [31:0] rdata_o,
  input wire cmd_clk_i,
  input wire term_on_o,
  input wire write_sel_o,
  input wire [7:0] term_ohms_o,
  input wire term_undefined_o,
  input wire code_reserved_o
);
  reg [4:0] since_r;
  reg ck_r;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // cycles since the command clock rose, saturating
  always @(posedge mclk_i) begin
    ck_r <= cmd_clk_i;
    if (rst_i || (cmd_clk_i && !ck_r)) since_r <= 5'h00;
    else if (since_r != 5'h1f) since_r <= since_r + 5'h01;
  end
  sequence s_settle;
    term_undefined_o [*5] ##1 !term_undefined_o;
  endsequence
  property p_reset_clear;
    $fell(rst_i) |-> !term_on_o && !write_sel_o && term_ohms_o == 8'h00 && rdata_o == 32'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  property p_sel_on;
    write_sel_o |-> term_on_o;
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("write strength while off");
  property p_off_ohms;
    !term_on_o |-> term_ohms_o == 8'h00;
  endproperty
  a_off_ohms: assert property (p_off_ohms) else $error("ohms while off");
  property p_settle;
    $rose(term_undefined_o) |-> s_settle;
  endproperty
  a_settle: assert property (p_settle) else $error("settle window length");
  property p_change_flag;
    $changed(write_sel_o) |-> ##[0:1] term_undefined_o;
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("no settle window");
  property p_ticks_only;
    $changed(term_on_o) || $changed(write_sel_o) |-> since_r <= 5'h07;
  endproperty
  a_ticks_only: assert property (p_ticks_only) else $error("change off a tick");
  property p_res_nom;
    wr_i && addr_i == 4'h0 && wdata_i[2:0] >= 3'h6 |-> ##[1:3] code_reserved_o;
  endproperty
  a_res_nom: assert property (p_res_nom) else $error("nominal code not flagged");
  property p_res_wr;
    wr_i && addr_i == 4'h4 && wdata_i[1:0] == 2'h3 |-> ##[1:3] code_reserved_o;
  endproperty
  a_res_wr: assert property (p_res_wr) else $error("write code not flagged");
endmodule
bind dtc_core dtc_core_assertions i_chk (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rdata_o(rdata_o), .cmd_clk_i(cmd_clk_i),
  .term_on_o(term_on_o), .write_sel_o(write_sel_o), .term_ohms_o(term_ohms_o),
  .term_undefined_o(term_undefined_o), .code_reserved_o(code_reserved_o));

/* testbench/dtc_ctrl_model.sv */
// controller model: command clock, termination pin, write commands
// assumes one frame of 24 command clocks of 8 mclk per start pulse
`timescale 1ns/10ps
module dtc_ctrl_model (
  input wire mclk_i,
  input wire start_i,
  input wire [3:0] pin_len_i,
  input wire wr_en_i,
  input wire [3:0] wr_at_i,
  input wire chop_i,
  output wire cmd_clk_o,
  output reg pin_o = 1'b0,
  output reg write_o = 1'b0,
  output reg chop_o = 1'b0,
  output wire busy_o
);
  reg [7:0] cnt_r = 8'hc0;
  assign busy_o = cnt_r < 8'hc0;
  assign cmd_clk_o = busy_o && cnt_r[2]; // stands low outside frames
  // new values three mclk before each rising command clock edge
  always @(posedge mclk_i) begin
    if (start_i) cnt_r <= 8'h00;
    else if (busy_o) cnt_r <= cnt_r + 8'h01;
    if (busy_o && cnt_r[2:0] == 3'h0) begin
      pin_o <= cnt_r[7:3] < {1'b0, pin_len_i};
      write_o <= wr_en_i && cnt_r[7:3] == {1'b0, wr_at_i};
      chop_o <= (wr_en_i && cnt_r[7:3] == {1'b0, wr_at_i}) ? chop_i : ~chop_o;
    end else if (!busy_o) chop_o <= ~chop_o; // no stale value between frames
  end
endmodule

/* testbench/dynamic_termination_control_tb.sv */
// bench for dtc_core: register port and controller frames
// assumes dtc_ctrl_model and the bound checker
`timescale 1ns/10ps
module dynamic_termination_control_tb;
  reg mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, start = 1'b0, en = 1'b0, chp = 1'b0;
  reg [3:0] addr = 4'h0, plen = 4'h0, at = 4'h0;
  reg [31:0] wd = 32'h0;
  reg [16:0] lfsr = 17'h1548b;
  reg [7:0] nohm = 8'h0, wohm = 8'h0;
  reg ck_q = 1'b0, pin_q = 1'b0, rv = 1'b0, sel_q = 1'b0, on_q = 1'b0;
  reg [31:0] q[$];
  wire [31:0] rdata;
  wire [7:0] ohms;
  wire ck, pin, wcmd, wchop, busy, on, sel, und, res;
  integer errors = 0, n_tests = 0, cyc = 0, t_w = 0, t_p = 0, t_r = 0, lat = 0, hold = 0;
  integer n_sel = 0, n_on = 0, i;
  initial forever #20 mclk = ~mclk;
  dtc_core i_dut (.mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cmd_clk_i(ck), .termination_pin_i(pin), .cmd_write_i(wcmd),
    .cmd_chop_i(wchop), .term_on_o(on), .write_sel_o(sel), .term_ohms_o(ohms),
    .term_undefined_o(und), .code_reserved_o(res));
  dtc_ctrl_model i_ctrl (.mclk_i(mclk), .start_i(start), .pin_len_i(plen), .wr_en_i(en),
    .wr_at_i(at), .chop_i(chp), .cmd_clk_o(ck), .pin_o(pin), .write_o(wcmd), .chop_o(wchop),
    .busy_o(busy));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  function [16:0] lfsr_next(input [16:0] v);
    lfsr_next = {v[15:0], v[16] ^ v[13]};
  endfunction
  task reg_wr(input [3:0] a, input [31:0] d);
    begin
      lfsr = lfsr_next(lfsr);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wd <= {lfsr, 15'h0} | d; // junk upper bits
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task reg_rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      q.push_back(e);
      @(posedge mclk);
      rd <= 1'b0;
    end
  endtask
  task frame(input [2:0] nc, input [7:0] no, input [1:0] wc, input [7:0] alcwl, input [3:0] pl,
    input e, input [3:0] wa, input c);
    integer s, o, k;
    begin
      reg_wr(4'h0, {29'h0, nc});
      reg_wr(4'h4, {30'h0, wc});
      reg_wr(4'h8, {24'h0, alcwl});
      reg_rd(4'h4, {30'h0, wc});
      reg_rd(4'h8, {24'h0, alcwl});
      lat = alcwl[3:0] + alcwl[7:4] - 2;
      hold = c ? 4 : 6;
      nohm = no;
      wohm = wc == 2'h1 ? 8'h3c : wc == 2'h2 ? 8'h78 : 8'h00;
      s = n_sel;
      o = n_on;
      @(posedge mclk);
      {plen, en, at, chp, start} <= {pl, e, wa, c, 1'b1};
      @(posedge mclk);
      start <= 1'b0;
      for (k = 0; k < 400 && (k < 2 || busy !== 1'b0); k = k + 1) @(posedge mclk);
      check(n_sel - s, e && wc != 2'h0);
      check(n_on - o, 1);
      reg_rd(4'hc, 32'h0);
      $display("frame with code %0d done", nc);
    end
  endtask
  // read scoreboard and link timing monitor
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    {rv, ck_q, sel_q, on_q} <= {rd, ck, sel, on};
    if (rv) check(rdata, q.pop_front());
    if (ck && !ck_q) begin
      pin_q <= pin;
      if (wcmd) t_w = cyc;
      if (pin && !pin_q) t_p = cyc;
    end
    if (on && !on_q) begin
      n_on = n_on + 1;
      check((cyc - t_p) / 8, lat);
      check(ohms, nohm);
    end
    if (sel && !sel_q) begin
      {n_sel, t_r} = {n_sel + 1, cyc};
      check((cyc - t_w) / 8, lat);
      check(ohms, wohm);
    end
    if (!sel && sel_q) begin
      check(cyc - t_r, hold * 8);
      check(ohms, nohm);
    end
    if (cyc > 4000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    reg_rd(4'h0, 32'h0);
    reg_rd(4'h4, 32'h0);
    reg_rd(4'h8, 32'h5);
    reg_wr(4'h6, 32'hff);
    reg_rd(4'h2, 32'h0);
    for (i = 6; i < 9; i = i + 1) begin
      reg_wr(i == 8 ? 4'h4 : 4'h0, i == 8 ? 32'h3 : i);
      reg_rd(4'hc, 32'h800);
      reg_wr(i == 8 ? 4'h4 : 4'h0, 32'h0);
    end
    frame(3'h1, 8'h3c, 2'h2, 8'h05, 4'h8, 1'b1, 4'h1, 1'b1);
    frame(3'h2, 8'h78, 2'h1, 8'h05, 4'h8, 1'b1, 4'h1, 1'b0);
    frame(3'h3, 8'h28, 2'h1, 8'h26, 4'ha, 1'b1, 4'h2, 1'b0);
    frame(3'h3, 8'h28, 2'h0, 8'h05, 4'h8, 1'b1, 4'h1, 1'b0);
    frame(3'h4, 8'h14, 2'h2, 8'h05, 4'h4, 1'b0, 4'h0, 1'b0);
    frame(3'h5, 8'h1e, 2'h1, 8'h05, 4'h4, 1'b0, 4'h0, 1'b0);
    frame(3'h0, 8'h00, 2'h2, 8'h15, 4'h6, 1'b1, 4'h1, 1'b1);
    test_done;
  end
endmodule
